/* File: cr_buf_cfg_pkg.sv */
// constants shared by the relation buffer configuration bank
// assumes a 32-bit apb with 12-bit byte addresses
package cr_buf_cfg_pkg;

    localparam int unsigned REL_COUNT = 8;
    localparam int unsigned PADDR_W = 12;
    localparam int unsigned FIELD_W = 10;
    localparam int unsigned BYTE_ADDR_W = 12;

    // relation words, one aligned word each, relations 14 to 21
    localparam logic [11:0] OFS_COMM_RELATION_14_BUF_CFG = 12'h034;
    localparam logic [11:0] OFS_COMM_RELATION_15_BUF_CFG = 12'h038;
    localparam logic [11:0] OFS_COMM_RELATION_16_BUF_CFG = 12'h03c;
    localparam logic [11:0] OFS_COMM_RELATION_17_BUF_CFG = 12'h040;
    localparam logic [11:0] OFS_COMM_RELATION_18_BUF_CFG = 12'h044;
    localparam logic [11:0] OFS_COMM_RELATION_19_BUF_CFG = 12'h048;
    localparam logic [11:0] OFS_COMM_RELATION_20_BUF_CFG = 12'h04c;
    localparam logic [11:0] OFS_COMM_RELATION_21_BUF_CFG = 12'h050;
    localparam logic [11:0] REL_STRIDE = 12'h004;

    // event status and mask
    localparam logic [11:0] OFS_NEW_DATA_STATUS = 12'h080;
    localparam logic [11:0] OFS_NEW_DATA_MASK = 12'h084;

    // field positions inside a relation word
    localparam int unsigned START_LSB = 2;
    localparam int unsigned START_MSB = 11;
    localparam int unsigned END_LSB = 16;
    localparam int unsigned END_MSB = 25;
    localparam int unsigned ZERO_DATA_BIT = 27;
    localparam int unsigned IRQ_CODE_LSB = 28;
    localparam int unsigned IRQ_CODE_MSB = 31;

    localparam logic [31:0] REL_WORD_RESET = 32'h00000ffc;
    localparam logic [31:0] REL_WORD_WMASK = 32'hfbff0ffc;
    localparam logic [3:0] IRQ_CODE_MIN = 4'h1;
    localparam logic [3:0] IRQ_CODE_MAX = 4'h9;
    localparam logic [1:0] BYTE_PAD = 2'h0;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;

endpackage

/* File: cr_buf_cfg.sv */
// buffer placement and new-data configuration bank for relations 14 to 21
// assumes an apb3 master on i_clk; event and mode inputs come from logic on i_clk
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps

module cr_buf_cfg (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire logic i_paged_placement,
    input wire logic [7:0] i_new_data,
    input wire logic [7:0] i_zero_upd,
    input wire logic [7:0] i_zero_upd_val,
    output logic o_explicit_placement,
    output logic [7:0][11:0] o_buf_start,
    output logic [7:0][11:0] o_buf_end,
    output logic [7:0] o_zero_data,
    output logic o_irq
);

    typedef struct packed {
        logic [7:0][31:0] word;
        logic [7:0] status;
        logic [7:0] mask;
        logic [31:0] rdata;
        logic slverr;
        logic explicit_out;
        logic [7:0][11:0] start_out;
        logic [7:0][11:0] end_out;
        logic [7:0] zero_out;
        logic irq;
    } state_t;

    state_t st;
    state_t next_st;

    logic setup_phase;
    logic write_take;
    logic in_rel_range;
    logic rel_hit;
    logic status_hit;
    logic mask_hit;
    logic [11:0] rel_ofs;
    logic [2:0] rel_idx;

    // zero wait states: the answer is ready at the first access edge
    assign o_pready = 1'b1;
    assign o_prdata = st.rdata;
    assign o_pslverr = st.slverr;
    assign o_explicit_placement = st.explicit_out;
    assign o_buf_start = st.start_out;
    assign o_buf_end = st.end_out;
    assign o_zero_data = st.zero_out;
    assign o_irq = st.irq;

    assign setup_phase = i_psel & ~i_penable;
    assign write_take = i_psel & i_penable & i_pwrite;

    // word decode over the relation block
    assign rel_ofs = i_paddr - cr_buf_cfg_pkg::OFS_COMM_RELATION_14_BUF_CFG;
    assign rel_idx = rel_ofs[4:2];
    assign in_rel_range = (i_paddr >= cr_buf_cfg_pkg::OFS_COMM_RELATION_14_BUF_CFG)
        && (i_paddr <= cr_buf_cfg_pkg::OFS_COMM_RELATION_21_BUF_CFG);
    assign rel_hit = in_rel_range && (i_paddr[1:0] == 2'h0);
    assign status_hit = (i_paddr == cr_buf_cfg_pkg::OFS_NEW_DATA_STATUS);
    assign mask_hit = (i_paddr == cr_buf_cfg_pkg::OFS_NEW_DATA_MASK);

    always_comb begin
        logic [31:0] merged;
        logic [3:0] code;
        logic [7:0] w1c;
        logic [7:0] armed;
        merged = 32'h0;
        code = 4'h0;
        w1c = 8'h00;
        armed = 8'h00;
        next_st = st;

        // software writes take effect at the access edge
        if (write_take && rel_hit) begin
            merged = i_pwdata & cr_buf_cfg_pkg::REL_WORD_WMASK;
            next_st.word[rel_idx] = merged;
        end
        if (write_take && mask_hit) begin
            next_st.mask = i_pwdata[7:0];
        end
        if (write_take && status_hit) begin
            w1c = i_pwdata[7:0];
        end

        for (int i = 0; i < 8; i++) begin
            // hardware update of the zero-data bit wins over a software write
            if (i_zero_upd[i]) begin
                next_st.word[i][cr_buf_cfg_pkg::ZERO_DATA_BIT] = i_zero_upd_val[i];
            end
            code = st.word[i][cr_buf_cfg_pkg::IRQ_CODE_MSB:cr_buf_cfg_pkg::IRQ_CODE_LSB];
            armed[i] = (code >= cr_buf_cfg_pkg::IRQ_CODE_MIN)
                && (code <= cr_buf_cfg_pkg::IRQ_CODE_MAX);
            // set beats the write-one clear in the same cycle
            next_st.status[i] = (st.status[i] & ~w1c[i]) | (i_new_data[i] & armed[i]);

            // placement outputs only carry fields in explicit mode
            if (i_paged_placement) begin
                next_st.start_out[i] = 12'h000;
                next_st.end_out[i] = 12'h000;
            end else begin
                next_st.start_out[i] = {st.word[i][cr_buf_cfg_pkg::START_MSB:cr_buf_cfg_pkg::START_LSB],
                    cr_buf_cfg_pkg::BYTE_PAD};
                next_st.end_out[i] = {st.word[i][cr_buf_cfg_pkg::END_MSB:cr_buf_cfg_pkg::END_LSB],
                    cr_buf_cfg_pkg::BYTE_PAD};
            end
            next_st.zero_out[i] = st.word[i][cr_buf_cfg_pkg::ZERO_DATA_BIT];
        end
        next_st.explicit_out = ~i_paged_placement;
        next_st.irq = |(next_st.status & st.mask);

        // read data is captured in the setup cycle so it stands through access
        if (setup_phase) begin
            next_st.slverr = 1'b0;
            next_st.rdata = 32'h0;
            if (rel_hit) begin
                next_st.rdata = st.word[rel_idx] & cr_buf_cfg_pkg::REL_WORD_WMASK;
            end else if (status_hit) begin
                next_st.rdata = {24'h0, st.status};
            end else if (mask_hit) begin
                next_st.rdata = {24'h0, st.mask};
            end else begin
                next_st.slverr = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 8; i++) begin
                st.word[i] <= cr_buf_cfg_pkg::REL_WORD_RESET;
                st.start_out[i] <= 12'h000;
                st.end_out[i] <= 12'h000;
            end
            st.status <= cr_buf_cfg_pkg::STATUS_RESET;
            st.mask <= cr_buf_cfg_pkg::MASK_RESET;
            st.rdata <= 32'h0;
            st.slverr <= 1'b0;
            st.explicit_out <= 1'b0;
            st.zero_out <= 8'h00;
            st.irq <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

endmodule

/* File: cr_buf_cfg_checker.sv */
// port assertions for the relation configuration bank
// assumes it is bound into every cr_buf_cfg instance
`timescale 1ns/1ps
module cr_buf_cfg_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_paged_placement,
    input wire logic [7:0] i_new_data,
    input wire logic [7:0] i_zero_upd,
    input wire logic [7:0] i_zero_upd_val,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    input wire logic o_explicit_placement,
    input wire logic [7:0][11:0] o_buf_start,
    input wire logic [7:0][11:0] o_buf_end,
    input wire logic [7:0] o_zero_data,
    input wire logic o_irq
);
    wire logic wr = i_psel && i_penable && i_pwrite;
    wire logic su = i_psel && !i_penable;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    paged_zero_a: assert property ($past(i_rst_n) |->
        o_explicit_placement != $past(i_paged_placement)
        && (!$past(i_paged_placement) || (o_buf_start == '0 && o_buf_end == '0))) else $error("bad mode");
    start_field_a: assert property (wr && i_paddr == 12'h034 ##1 !i_paged_placement
        |=> o_buf_start[0] == {$past(i_pwdata[11:2], 2), 2'b00}) else $error("bad start");
    end_field_a: assert property (wr && i_paddr == 12'h050 ##1 !i_paged_placement
        |=> o_buf_end[7] == {$past(i_pwdata[25:16], 2), 2'b00}) else $error("bad end");
    zero_hw_a: assert property (i_zero_upd[2] |=> ##1
        o_zero_data[2] == $past(i_zero_upd_val[2], 2)) else $error("bad zero bit");
    irq_clear_a: assert property (wr && i_paddr == 12'h080 && i_pwdata[7:0] == 8'hff
        && i_new_data == 8'h00 ##1 i_new_data == 8'h00 |=> !o_irq) else $error("irq stuck");
    unmapped_err_a: assert property (su && i_paddr == 12'h030
        |=> o_pslverr && o_prdata == 32'h0) else $error("no error");
    reserved_zero_a: assert property (su && i_paddr inside {[12'h034:12'h050]} && i_paddr[1:0] == 2'b00
        |=> !o_pslverr && (o_prdata & 32'h0400f003) == 32'h0) else $error("bad read");
endmodule
bind cr_buf_cfg cr_buf_cfg_checker chk (.*);

/* File: cr_buf_cfg_tb_top.sv */
// self-checking bench for the relation configuration bank
// assumes the checker file is compiled alongside
`timescale 1ns/1ps
module cr_buf_cfg_tb_top;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic i_paged_placement = 1'b0, o_pready, o_pslverr, o_explicit_placement, o_irq, err;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, rd, d, o_prdata;
    logic [7:0] i_new_data = 8'h00, i_zero_upd = 8'h00, i_zero_upd_val = 8'h00, o_zero_data;
    logic [7:0][11:0] o_buf_start, o_buf_end;
    int n_errors = 0, checks_done = 0, seed = 87;
    cr_buf_cfg uut (.*);
    always #2 i_clk = ~i_clk;
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge i_clk);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, v};
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        {i_psel, i_penable} <= 2'b00;
    endtask
    // new-data pulse, then room for the registered irq to settle
    task pulse;
        @(posedge i_clk);
        i_new_data <= 8'h01;
        @(posedge i_clk);
        i_new_data <= 8'h00;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    function logic irq_exp(input logic [3:0] c);
        return c >= 4'h1 && c <= 4'h9;
    endfunction
    task conclude;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #60000;
        n_errors++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 12'h034 + 12'(4 * i), 32'h0);
            chk(rd, 32'h00000ffc);
            chk(32'(o_buf_start[i]), 32'h00000ffc);
        end
        $display("reset test end");
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 32'hffffffff : $random(seed);
            apb(1'b1, 12'h034 + 12'(4 * i), d);
            apb(1'b0, 12'h034 + 12'(4 * i), 32'h0);
            chk(rd, d & 32'hfbff0ffc);
            chk({o_zero_data[i], 7'h00, o_buf_end[i], o_buf_start[i]}, {d[27], 7'h00, d[25:16], 2'h0, d[11:2], 2'h0});
        end
        $display("field test end");
        @(posedge i_clk);
        i_paged_placement <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        chk(32'({o_explicit_placement, o_buf_start[7], o_buf_end[7]}), 32'h0);
        @(posedge i_clk);
        i_paged_placement <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
        chk(32'(o_explicit_placement), 32'h1);
        chk(32'(o_buf_start[0]), 32'h00000ffc);
        apb(1'b0, 12'h030, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        $display("map test end");
        apb(1'b1, 12'h084, 32'h1);
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, 12'h034, {4'(c), 28'h0000ffc});
            pulse();
            chk(32'(o_irq), 32'(irq_exp(4'(c))));
            apb(1'b1, 12'h080, 32'h000000ff);
        end
        apb(1'b1, 12'h034, 32'h10000ffc);
        apb(1'b1, 12'h084, 32'h0);
        pulse();
        chk(32'(o_irq), 32'h0);
        apb(1'b1, 12'h084, 32'h1);
        apb(1'b0, 12'h084, 32'h0);
        chk({31'h0, o_irq}, 32'h1);
        apb(1'b1, 12'h080, 32'h000000ff);
        $display("irq test end");
        @(posedge i_clk);
        {i_zero_upd, i_zero_upd_val} <= 16'h0404;
        @(posedge i_clk);
        {i_zero_upd, i_zero_upd_val} <= 16'h0000;
        apb(1'b0, 12'h03c, 32'h0);
        chk(32'(rd[27]), 32'h1);
        chk(32'(o_zero_data[2]), 32'h1);
        @(posedge i_clk);
        {i_zero_upd, i_zero_upd_val} <= 16'h0400;
        @(posedge i_clk);
        {i_zero_upd, i_zero_upd_val} <= 16'h0000;
        apb(1'b0, 12'h03c, 32'h0);
        chk(32'(rd[27]), 32'h0);
        chk(32'(o_zero_data[2]), 32'h0);
        $display("zero test end");
        conclude();
    end
endmodule
